// ### hdl/eqf_pkg.sv
// Package: constants and types of the nine-tap equalizer FIR
`default_nettype none
package eqf_pkg;
    // ==========================================================
    // Widths and tap layout
    localparam int SAMPLE_W   = 8;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int NTAPS      = 9;
    localparam int CTR_TAP    = 4;
    localparam int COEF_W     = 18;
    localparam int NCT_W      = 12;
    localparam int FRAC_W     = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int MODE_W     = 2;
    localparam int WSEL_W     = 3;
    localparam int IDX_LSB    = 2;
    localparam int IDX_W      = 4;

    // ==========================================================
    // Mode field and weight select (0 is 2^-10, 6 is 2^-16)
    localparam logic [1:0] MODE_BYPASS = 2'h0;
    localparam logic [1:0] MODE_FIR    = 2'h2;
    localparam logic [2:0] WSEL_MAX    = 3'h6;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CONV   = 8'h04;
    localparam logic [7:0] REG_STAT   = 8'h08;
    localparam logic [7:0] REG_BANK_A = 8'h40;
    localparam logic [7:0] REG_BANK_B = 8'h80;
    localparam logic [7:0] BANK_MASK  = 8'hc0;

    // ==========================================================
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SHARE    = 2;
    localparam int CTRL_MERGE    = 3;
    localparam int CTRL_WSEL_LSB = 4;
    localparam int CONV_SINGLE   = 0;
    localparam int CONV_SIN_IN   = 1;
    localparam int STAT_EFF_LSB  = 0;
    localparam int STAT_OVALID   = 2;
    localparam int STAT_FVALID   = 3;

    // Center tap resets to unity gain, so the filter starts flat
    localparam logic [17:0] CENTER_RST = 18'h10000;

    // ==========================================================
    // Effective filter setting after the converter-mode gate
    typedef enum logic [1:0] {
        EFF_BYPASS,
        EFF_DUAL,
        EFF_SINGLE,
        EFF_TVAR
    } eqf_eff_t;
endpackage
`default_nettype wire

// ### hdl/eqf_fifo.sv
// Module: synchronous sample FIFO in front of the equalizer
`timescale 1ns/1ns
`default_nettype none
module eqf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        rdy;
    } eqf_fifo_st_t;

    eqf_fifo_st_t st_r;
    eqf_fifo_st_t st_nxt;
    logic         push;
    logic         pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == LAST_C) ? '0 : p + AW'(1);
    endfunction

    // Ready is a registered "not full"; a full FIFO refuses input
    assign push      = in_valid && st_r.rdy;
    assign pop       = out_valid && out_ready;
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign in_ready  = st_r.rdy;

    // Next state
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = next_ptr(st_r.wp);
        end
        if (pop) begin
            st_nxt.rp = next_ptr(st_r.rp);
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        st_nxt.rdy = (st_nxt.cnt != DEPTH_C);
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r     <= '0;
            st_r.rdy <= 1'b1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    a_fifo_full_stop: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r.cnt == DEPTH_C) |-> !in_ready)
        else $error("FIFO offers ready while full");
endmodule
`default_nettype wire

// ### hdl/eqf_equalizer_fir.sv
// Module: nine-tap programmable equalizer FIR on converter samples
// ==========================================================
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module eqf_equalizer_fir #(
    parameter int SW    = eqf_pkg::SAMPLE_W,
    parameter int DEPTH = eqf_pkg::FIFO_DEPTH
) (
    input  wire logic                        REF_CLK,
    input  wire logic                        NRST,
    input  wire logic                        CE,
    input  wire logic [eqf_pkg::ADDR_W-1:0]  ADDR,
    input  wire logic [eqf_pkg::DATA_W-1:0]  WDATA,
    input  wire logic                        WR,
    input  wire logic                        RD,
    output logic [eqf_pkg::DATA_W-1:0]       RDATA,
    input  wire logic                        IN_VALID,
    input  wire logic [SW-1:0]               IN_A,
    input  wire logic [SW-1:0]               IN_B,
    output logic                             IN_READY,
    output logic                             OUT_VALID,
    output logic [SW-1:0]                    OUT_A,
    output logic [SW-1:0]                    OUT_B,
    input  wire logic                        OUT_READY
);
    import eqf_pkg::*;

    // ==========================================================
    // Arithmetic sizing
    // Products are aligned to the 2^-16 grid; 6 bits of shift and
    // 4 bits of growth for nine terms keep the sum exact.
    localparam int ACC_W = SW + COEF_W + 10;
    localparam logic signed [ACC_W-1:0] HALF_LSB =
        ACC_W'(1) <<< (FRAC_W - 1);
    localparam logic signed [ACC_W-1:0] SAT_HI =
        (ACC_W'(1) <<< (SW - 1)) - ACC_W'(1);
    localparam logic signed [ACC_W-1:0] SAT_LO = -SAT_HI - ACC_W'(1);
    localparam int SEXT_W = COEF_W - NCT_W;

    typedef logic [NTAPS-1:0][SW-1:0]     eqf_win_t;
    typedef logic [NTAPS-1:0][COEF_W-1:0] eqf_bank_t;

    // ==========================================================
    // State
    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic              share;
        logic              merge;
        logic [WSEL_W-1:0] wsel;
        logic              omode;
        logic              sin;
        eqf_bank_t         bank_a;
        eqf_bank_t         bank_b;
        eqf_win_t          hist_a;
        eqf_win_t          hist_b;
        logic [SW-1:0]     out_a;
        logic [SW-1:0]     out_b;
        logic              out_v;
        logic [DATA_W-1:0] rdata;
    } eqf_state_t;

    eqf_state_t        st_r;
    eqf_state_t        st_nxt;
    eqf_eff_t          eff;
    eqf_win_t          win_a;
    eqf_win_t          win_b;
    eqf_bank_t         cf_b;
    logic              f_valid;
    logic              f_ready;
    logic [2*SW-1:0]   f_data;
    logic [SW-1:0]     f_a;
    logic [SW-1:0]     f_b;
    logic              pop;

    // ==========================================================
    // Functions

    // Effective setting: an illegal mix of mode, share, merge and
    // converter mode falls back to bypass rather than a wrong filter.
    function automatic eqf_eff_t eff_decode(
        input logic [MODE_W-1:0] mode,
        input logic              share,
        input logic              merge,
        input logic              omode,
        input logic              sin
    );
        eff_decode = EFF_BYPASS;
        if (mode == MODE_FIR) begin
            if (!share && !merge && !omode) begin
                eff_decode = EFF_DUAL;
            end else if (share && merge && omode && sin) begin
                eff_decode = EFF_SINGLE;
            end else if (!share && merge && omode && !sin) begin
                eff_decode = EFF_TVAR;
            end
        end
    endfunction

    // Address hits tap k of the bank at base
    function automatic logic bank_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base
    );
        bank_hit = ((addr & BANK_MASK) == base) &&
                   (addr[IDX_LSB-1:0] == '0) &&
                   (int'(addr[IDX_LSB +: IDX_W]) < NTAPS);
    endfunction

    // Center keeps 18 bits; side taps keep 12, sign extended
    function automatic logic [COEF_W-1:0] coef_fmt(
        input logic [IDX_W-1:0]  k,
        input logic [DATA_W-1:0] w
    );
        if (int'(k) == CTR_TAP) begin
            coef_fmt = w[COEF_W-1:0];
        end else begin
            coef_fmt = {{SEXT_W{w[NCT_W-1]}}, w[NCT_W-1:0]};
        end
    endfunction

    // Coefficient readback, sign extended to the bus width
    function automatic logic [DATA_W-1:0] coef_rd(
        input logic [COEF_W-1:0] c
    );
        coef_rd = {{(DATA_W-COEF_W){c[COEF_W-1]}}, c};
    endfunction

    // Nine-term sum on the 2^-16 grid
    function automatic logic signed [ACC_W-1:0] tap_sum(
        input eqf_win_t          win,
        input eqf_bank_t         cf,
        input logic [WSEL_W-1:0] wsel
    );
        logic signed [ACC_W-1:0]       acc;
        logic signed [SW+COEF_W-1:0]   pw;
        logic signed [ACC_W-1:0]       prod;
        logic [WSEL_W-1:0]             sh;
        acc = '0;
        // Out-of-range settings act as the finest weight
        sh = (wsel > WSEL_MAX) ? '0 : WSEL_MAX - wsel;
        for (int k = 0; k < NTAPS; k++) begin
            pw   = $signed(win[k]) * $signed(cf[k]);
            prod = ACC_W'(pw);
            if (k != CTR_TAP) begin
                prod = prod <<< sh;
            end
            acc = acc + prod;
        end
        tap_sum = acc;
    endfunction

    // Round half up, then clip to the sample range
    function automatic logic [SW-1:0] round_sat(
        input logic signed [ACC_W-1:0] acc
    );
        logic signed [ACC_W-1:0] r;
        r = (acc + HALF_LSB) >>> FRAC_W;
        if (r > SAT_HI) begin
            round_sat = SAT_HI[SW-1:0];
        end else if (r < SAT_LO) begin
            round_sat = SAT_LO[SW-1:0];
        end else begin
            round_sat = r[SW-1:0];
        end
    endfunction

    // ==========================================================
    // Input FIFO, one word holds the A and B samples of a step
    eqf_fifo #(
        .WIDTH (2*SW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (NRST),
        .ce        (CE),
        .in_valid  (IN_VALID),
        .in_ready  (IN_READY),
        .in_data   ({IN_A, IN_B}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // Drain only when the output slot frees, so back-pressure from
    // the transport side fills the FIFO and stalls the converter.
    assign f_a     = f_data[2*SW-1:SW];
    assign f_b     = f_data[SW-1:0];
    assign f_ready = !st_r.out_v || OUT_READY;
    assign pop     = f_valid && f_ready && CE;
    assign eff     = eff_decode(st_r.mode, st_r.share, st_r.merge,
                                st_r.omode, st_r.sin);

    // Time-varying filtering uses bank B for the odd samples
    assign cf_b = (eff == EFF_SINGLE) ? st_r.bank_a : st_r.bank_b;

    // ==========================================================
    // Next state: register port, sample history, filter output
    always_comb begin
        st_nxt = st_r;
        win_a  = '0;
        win_b  = '0;

        // Register writes
        if (WR) begin
            if (ADDR == REG_CTRL) begin
                st_nxt.mode  = WDATA[CTRL_MODE_LSB +: MODE_W];
                st_nxt.share = WDATA[CTRL_SHARE];
                st_nxt.merge = WDATA[CTRL_MERGE];
                st_nxt.wsel  = WDATA[CTRL_WSEL_LSB +: WSEL_W];
            end else if (ADDR == REG_CONV) begin
                st_nxt.omode = WDATA[CONV_SINGLE];
                st_nxt.sin   = WDATA[CONV_SIN_IN];
            end else if (bank_hit(ADDR, REG_BANK_A)) begin
                st_nxt.bank_a[ADDR[IDX_LSB +: IDX_W]] =
                    coef_fmt(ADDR[IDX_LSB +: IDX_W], WDATA);
            end else if (bank_hit(ADDR, REG_BANK_B)) begin
                st_nxt.bank_b[ADDR[IDX_LSB +: IDX_W]] =
                    coef_fmt(ADDR[IDX_LSB +: IDX_W], WDATA);
            end
        end

        // Read data stand for exactly one cycle; unmapped reads zero
        st_nxt.rdata = '0;
        if (RD) begin
            if (ADDR == REG_CTRL) begin
                st_nxt.rdata[CTRL_MODE_LSB +: MODE_W] = st_r.mode;
                st_nxt.rdata[CTRL_SHARE] = st_r.share;
                st_nxt.rdata[CTRL_MERGE] = st_r.merge;
                st_nxt.rdata[CTRL_WSEL_LSB +: WSEL_W] = st_r.wsel;
            end else if (ADDR == REG_CONV) begin
                st_nxt.rdata[CONV_SINGLE] = st_r.omode;
                st_nxt.rdata[CONV_SIN_IN] = st_r.sin;
            end else if (ADDR == REG_STAT) begin
                st_nxt.rdata[STAT_EFF_LSB +: MODE_W] = eff;
                st_nxt.rdata[STAT_OVALID] = st_r.out_v;
                st_nxt.rdata[STAT_FVALID] = f_valid;
            end else if (bank_hit(ADDR, REG_BANK_A)) begin
                st_nxt.rdata =
                    coef_rd(st_r.bank_a[ADDR[IDX_LSB +: IDX_W]]);
            end else if (bank_hit(ADDR, REG_BANK_B)) begin
                st_nxt.rdata =
                    coef_rd(st_r.bank_b[ADDR[IDX_LSB +: IDX_W]]);
            end
        end

        // Output slot empties when the consumer takes it
        if (st_r.out_v && OUT_READY) begin
            st_nxt.out_v = 1'b0;
        end

        // Shift one sample pair in; index 0 is the newest
        if (pop) begin
            st_nxt.hist_a = {st_r.hist_a[NTAPS-2:0], f_a};
            st_nxt.hist_b = {st_r.hist_b[NTAPS-2:0], f_b};
        end

        // Windows, newest first. Interleaved order is B0 A0 B1 A1..
        // so the B output sees it from B0 and the A output from A0.
        for (int k = 0; k < NTAPS; k++) begin
            if (eff == EFF_DUAL) begin
                win_a[k] = st_nxt.hist_a[k];
                win_b[k] = st_nxt.hist_b[k];
            end else begin
                win_b[k] = (k % 2 != 0) ? st_nxt.hist_a[k/2]
                                        : st_nxt.hist_b[k/2];
                win_a[k] = (k % 2 != 0) ? st_nxt.hist_b[(k+1)/2]
                                        : st_nxt.hist_a[k/2];
            end
        end

        // Filter or pass the new pair into the output register
        if (pop) begin
            st_nxt.out_v = 1'b1;
            if (eff == EFF_BYPASS) begin
                st_nxt.out_a = f_a;
                st_nxt.out_b = f_b;
            end else begin
                st_nxt.out_a = round_sat(
                    tap_sum(win_a, st_r.bank_a, st_r.wsel));
                st_nxt.out_b = round_sat(
                    tap_sum(win_b, cf_b, st_r.wsel));
            end
        end
    end

    // ==========================================================
    // State register; coefficients reset to a unity filter
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            st_r                  <= '0;
            st_r.bank_a[CTR_TAP]  <= CENTER_RST;
            st_r.bank_b[CTR_TAP]  <= CENTER_RST;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register
    assign RDATA     = st_r.rdata;
    assign OUT_VALID = st_r.out_v;
    assign OUT_A     = st_r.out_a;
    assign OUT_B     = st_r.out_b;

    // ==========================================================
    // Assertions
    a_bypass_pass_through: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        pop && (eff == EFF_BYPASS)
        |=> OUT_VALID && (OUT_A == $past(f_a)) && (OUT_B == $past(f_b)))
        else $error("Bypass did not pass the sample pair unchanged");

    a_mode_zero_bypass: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (st_r.mode != MODE_FIR) || (st_r.share && !st_r.merge)
        |-> (eff == EFF_BYPASS))
        else $error("Filter active with a bypass setting");

    a_dual_mode_gate: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (eff == EFF_DUAL) |-> !st_r.omode && !st_r.share)
        else $error("Dual equalization outside dual-channel mode");

    a_single_mode_gate: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (eff == EFF_SINGLE) |-> st_r.omode && st_r.sin && st_r.merge)
        else $error("Single equalization outside single-channel mode");

    a_tvar_mode_gate: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        (eff == EFF_TVAR) |-> st_r.omode && !st_r.sin && !st_r.share)
        else $error("Time-varying filter outside dual-input mode");

    a_center_full_width: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        CE && WR && (ADDR == (REG_BANK_A | ADDR_W'(CTR_TAP << IDX_LSB)))
        |=> st_r.bank_a[CTR_TAP] == $past(WDATA[COEF_W-1:0]))
        else $error("Center tap lost bits on write");

    a_side_sign_ext: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        CE && WR && (ADDR == REG_BANK_B)
        |=> ($signed(st_r.bank_b[0]) ==
             $signed($past(WDATA[NCT_W-1:0]))))
        else $error("Side tap not stored as 12-bit signed value");

    a_out_held_stall: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        OUT_VALID && !OUT_READY
        |=> OUT_VALID && $stable(OUT_A) && $stable(OUT_B))
        else $error("Output changed while stalled");

    a_read_one_cycle: assert property (
        @(posedge REF_CLK) disable iff (!NRST)
        CE && RD && (ADDR == REG_CONV)
        |=> (RDATA[CONV_SINGLE] == st_r.omode) ##1
            ($past(CE) && !$past(RD) -> (RDATA == '0)))
        else $error("Read data wrong or held too long");
endmodule
`default_nettype wire

// ### bench/eqf_sink.sv
// Downstream transport model: takes filtered sample pairs, may stall
`timescale 1ns/1ns
`default_nettype none
module eqf_sink (
    input  wire logic       clk,
    input  wire logic       hold,
    input  wire logic       slow,
    input  wire logic       valid,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    output logic            ready
);
    logic [15:0] got_q[$];
    logic        ph = 1'b0;
    initial ready = 1'b0;
    // ==========================================================
    // Take a pair where both agree; slow mode accepts every other cycle
    always @(posedge clk) begin
        if (valid === 1'b1 && ready === 1'b1) begin
            got_q.push_back({a, b});
        end
        ph    <= ~ph;
        ready <= !hold && (!slow || ph);
    end
endmodule
`default_nettype wire

// ### bench/eqf_equalizer_fir_tb.sv
// Testbench: register access and sample stream checks of the equalizer
`timescale 1ns/1ns
`default_nettype none
module eqf_equalizer_fir_tb;
    import eqf_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        in_valid = 1'b0;
    logic [7:0]  in_a = 8'h00;
    logic [7:0]  in_b = 8'h00;
    logic        hold = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] rdata;
    logic        in_ready, out_valid, out_ready, r;
    logic [7:0]  out_a, out_b;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cnt;
    // ==========================================================
    // Clock, design and far-side model
    always #5 ref_clk = ~ref_clk;
    eqf_equalizer_fir #(.SW(8), .DEPTH(8)) uut (
        .REF_CLK(ref_clk), .NRST(nrst), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .IN_VALID(in_valid), .IN_A(in_a), .IN_B(in_b),
        .IN_READY(in_ready), .OUT_VALID(out_valid), .OUT_A(out_a),
        .OUT_B(out_b), .OUT_READY(out_ready));
    eqf_sink sink (.clk(ref_clk), .hold(hold), .slow(slow),
        .valid(out_valid), .a(out_a), .b(out_b), .ready(out_ready));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        @(negedge ref_clk);
        chk(rdata, exp);
    endtask
    // Center tap plus the mirrored side taps k and 8-k
    task automatic cf(input logic [7:0] base, input logic [31:0] c,
                      input int k, input logic [31:0] s);
        wr_reg(base + 8'h10, c);
        wr_reg(base + 8'(4 * k), s);
        wr_reg(base + 8'(32 - 4 * k), s);
    endtask
    // Ready is registered, so its level at the falling edge is what counts
    task automatic put(input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        in_valid <= 1'b1;
        in_a     <= a;
        in_b     <= b;
        do begin
            @(negedge ref_clk);
            r = in_ready;
            @(posedge ref_clk);
        end while (r !== 1'b1);
        in_valid <= 1'b0;
    endtask
    task automatic wait_q(input int n);
        for (int i = 0; i < 300 && sink.got_q.size() < n; i++) begin
            @(posedge ref_clk);
        end
        chk(32'(sink.got_q.size()), 32'(n));
    endtask
    // Constant input fills the whole history, so the output is x times sum
    task automatic steady(input int xa, input int xb, input logic [15:0] e);
        sink.got_q.delete();
        repeat (12) put(xa[7:0], xb[7:0]);
        wait_q(12);
        chk({16'h0, sink.got_q[11]}, {16'h0, e});
    endtask
    // Sum in 2^-16 units, round half up, clamp to the sample range
    function automatic logic [7:0] ey(int x, int c, int s, int w);
        longint acc;
        acc = (longint'(x) * s) <<< (6 - (w > 6 ? 6 : w));
        acc = acc + longint'(x) * c;
        acc = (acc + 32768) >>> 16;
        if (acc > 127) acc = 127;
        if (acc < -128) acc = -128;
        return acc[7:0];
    endfunction
    task automatic finish_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog: the sequence needs well under a tenth of this span
    initial begin
        #300000;
        error_cnt++;
        finish_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        rd_reg(REG_CTRL, 32'h0);
        rd_reg(REG_STAT, 32'h0);
        rd_reg(REG_BANK_A + 8'h10, 32'h10000);
        rd_reg(REG_BANK_B + 8'h10, 32'h10000);
        rd_reg(REG_BANK_A + 8'h24, 32'h0);
        rd_reg(8'h0c, 32'h0);
        wr_reg(REG_BANK_B, 32'hfff);
        rd_reg(REG_BANK_B, 32'hffffffff);
        wr_reg(REG_BANK_B + 8'h10, 32'h3ffff);
        rd_reg(REG_BANK_B + 8'h10, 32'hffffffff);
        // A write strobe is lost while the clock enable is low
        @(posedge ref_clk);
        ce <= 1'b0;
        wr_reg(REG_CTRL, 32'h2);
        ce <= 1'b1;
        rd_reg(REG_CTRL, 32'h0);
        // Bypass with share and merge set: fill until refused, drain slowly
        wr_reg(REG_CTRL, 32'hc);
        rd_reg(REG_STAT, 32'h0);
        hold <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sink.got_q.delete();
        cnt = 0;
        in_valid <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            in_a <= 8'(cnt) - 8'h80;
            in_b <= ~(8'(cnt) - 8'h80);
            @(negedge ref_clk);
            r = in_ready;
            @(posedge ref_clk);
            if (r) cnt++;
        end
        in_valid <= 1'b0;
        chk(32'(cnt >= 8 && cnt <= 10 && r === 1'b0), 32'h1);
        hold <= 1'b0;
        slow <= 1'b1;
        wait_q(cnt);
        foreach (sink.got_q[i]) begin
            chk({16'h0, sink.got_q[i]},
                {16'h0, 8'(i) - 8'h80, ~(8'(i) - 8'h80)});
        end
        slow <= 1'b0;
        // Dual channels, every side weight select
        wr_reg(REG_CONV, 32'h0);
        cf(REG_BANK_A, 32'h8000, 0, 32'h020);
        cf(REG_BANK_B, 32'h10000, 0, 32'h0);
        for (int w = 0; w < 8; w++) begin
            wr_reg(REG_CTRL, {25'h0, w[2:0], 4'h2});
            steady(40, -7, {ey(40, 32768, 64, w), 8'hf9});
        end
        rd_reg(REG_STAT, 32'h1);
        cf(REG_BANK_A, 32'h1ffff, 0, 32'h0);
        steady(100, -7, {8'h7f, 8'hf9});
        steady(-100, 9, {8'h80, 8'h09});
        // Single channel: gated off in dual mode, odd taps cross A and B
        wr_reg(REG_CTRL, 32'he);
        rd_reg(REG_STAT, 32'h0);
        wr_reg(REG_CONV, 32'h3);
        rd_reg(REG_CONV, 32'h3);
        rd_reg(REG_STAT, 32'h2);
        cf(REG_BANK_A, 32'h0, 1, 32'h080);
        steady(40, -40, {ey(-40, 0, 256, 0), ey(40, 0, 256, 0)});
        // Time-varying: bank A on A positions, bank B on B positions
        cf(REG_BANK_A, 32'h8000, 1, 32'h0);
        wr_reg(REG_CONV, 32'h1);
        // Share set without merge is not a legal mix and falls to bypass
        wr_reg(REG_CTRL, 32'h6);
        rd_reg(REG_STAT, 32'h0);
        wr_reg(REG_CTRL, 32'ha);
        rd_reg(REG_STAT, 32'h3);
        steady(40, -40, {8'h14, 8'hd8});
        finish_test();
    end
endmodule
`default_nettype wire
